// ===== common/dps_pkg.sv
// Shared constants and carriers for the program sequencer block.
// Assumes a single 40 MHz core clock and active-low asynchronous reset.
package dps_pkg;
  localparam int ADDR_W = 24;
  localparam int INSTR_W = 48;
  localparam int TIMER_W = 32;
  localparam int CACHE_SETS = 16;
  localparam int CACHE_WAYS = 2;
  localparam int SET_W = 4;
  localparam int TAG_W = ADDR_W - SET_W;
  localparam int LOOP_DEPTH = 6;
  localparam int LOOP_CNT_W = 32;
  localparam int STAT_DEPTH = 5;
  localparam int ASTAT_W = 32;
  localparam int MODE_W = 32;
  localparam int N_EXT_IRQ = 4;
  localparam int N_INT_IRQ = 9;
  localparam int N_SW_IRQ = 8;
  localparam int N_IRQ = N_EXT_IRQ + N_INT_IRQ + N_SW_IRQ;
  localparam int IRQ_IDX_W = 5;
  // Position of the timer among internal interrupts
  localparam int TIMER_IRQ_BIT = N_EXT_IRQ;
  localparam logic [ADDR_W-1:0] RESET_VECTOR = 24'h000008;
  localparam logic [ADDR_W-1:0] VECTOR_BASE = 24'h000000;
  localparam int VECTOR_SHIFT = 3;
  // Mode word bit positions for register bank selects and interrupt enable
  localparam int MODE_SRD_LO = 0;
  localparam int MODE_SRD_HI = 1;
  localparam int MODE_SAG1_LO = 2;
  localparam int MODE_SAG1_HI = 3;
  localparam int MODE_SAG2_LO = 4;
  localparam int MODE_SAG2_HI = 5;
  localparam int MODE_SMR = 6;
  localparam int MODE_IRPTEN = 12;
  localparam logic [MODE_W-1:0] MODE_RESET = 32'h00000000;

  typedef struct packed {
    logic data_lo;
    logic data_hi;
    logic agu1_lo;
    logic agu1_hi;
    logic agu2_lo;
    logic agu2_hi;
    logic mult_res;
  } dps_bank_sel_t;

  typedef struct packed {
    logic [ADDR_W-1:0] start;
    logic [ADDR_W-1:0] last;
    logic [LOOP_CNT_W-1:0] count;
  } dps_loop_t;

  typedef struct packed {
    logic [ASTAT_W-1:0] astat;
    logic [MODE_W-1:0] mode;
  } dps_status_t;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
    logic [INSTR_W-1:0] word;
  } dps_stage_t;
endpackage

// ===== hw/dps_icache.sv
`timescale 1ns/1ps
// Selective two-way set-associative instruction cache.
// Assumes lookups and fills use the fetch address of the same cycle.
module dps_icache #(
  parameter int SETS = dps_pkg::CACHE_SETS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [dps_pkg::ADDR_W-1:0] lookup_addr,
  output logic hit,
  output logic [dps_pkg::INSTR_W-1:0] hit_word,
  input wire logic fill_en,
  input wire logic [dps_pkg::ADDR_W-1:0] fill_addr,
  input wire logic [dps_pkg::INSTR_W-1:0] fill_word
);
  localparam int TW = dps_pkg::TAG_W;
  localparam int SW = dps_pkg::SET_W;

  logic [TW-1:0] tag_q [dps_pkg::CACHE_WAYS][SETS];
  logic [dps_pkg::INSTR_W-1:0] data_q [dps_pkg::CACHE_WAYS][SETS];
  logic [SETS-1:0] vld_q [dps_pkg::CACHE_WAYS];
  logic [SETS-1:0] lru_q;

  wire [SW-1:0] l_set = lookup_addr[SW-1:0];
  wire [TW-1:0] l_tag = lookup_addr[dps_pkg::ADDR_W-1:SW];
  wire [SW-1:0] f_set = fill_addr[SW-1:0];
  wire hit0 = vld_q[0][l_set] && tag_q[0][l_set] == l_tag;
  wire hit1 = vld_q[1][l_set] && tag_q[1][l_set] == l_tag;
  // Victim is the least recently used way
  wire victim = lru_q[f_set];

  // Combinational hit and word select
  assign hit = hit0 || hit1;
  assign hit_word = hit1 ? data_q[1][l_set] : data_q[0][l_set];

  // Valid bits and LRU state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vld_q[0] <= '0;
      vld_q[1] <= '0;
      lru_q <= '0;
    end else if (fill_en) begin
      vld_q[victim][f_set] <= 1'b1;
      lru_q[f_set] <= ~victim;
    end else if (hit) begin
      lru_q[l_set] <= ~hit1;
    end
  end

  // Tag and data arrays, no reset needed
  always_ff @(posedge clk) begin
    if (fill_en) begin
      tag_q[victim][f_set] <= fill_addr[dps_pkg::ADDR_W-1:SW];
      data_q[victim][f_set] <= fill_word;
    end
  end
endmodule

// ===== hw/dps_sequencer.sv
`timescale 1ns/1ps
// Program sequencer: fetch/decode/execute, loops, interrupts, timer, cache.
// Assumes program memory answers in the cycle after the address appears.
//
// Functional notes
// [RULE_01] Sequencer drives every fetch address
// [RULE_02] Program address is 24 bits
// [RULE_03] Instruction words are 48 bits wide
// [RULE_04] Controls loops and evaluates conditions
// [RULE_05] Hardware loop counter and loop stack
// [RULE_06] Overlapped fetch, decode, execute stages
// [RULE_07] Two-way cache holding 32 instructions
// [RULE_08] Cache only fetches colliding with data
// [RULE_09] Cache hit frees program memory
// [RULE_10] Alternate banks, primary after reset
// [RULE_11] Data file halves switch independently
// [RULE_12] Address generator halves switch independently
// [RULE_13] Four external, nine internal, eight software interrupts
// [RULE_14] Status stack five deep for these interrupts; code pushes status only for the external and timer interrupts
// [RULE_15] Exceptions interrupt; accepted any time
// [RULE_16] Enabled timer decrements every cycle
// [RULE_17] Zero count raises interrupt and expiry pin
// [RULE_18] Reload from period, continue next cycle
// [RULE_19] Loop end jumps back or pops
// [RULE_20] Bank select changes never disturb contents
module dps_sequencer #(
  parameter int LOOP_DEPTH = dps_pkg::LOOP_DEPTH,
  parameter int STAT_DEPTH = dps_pkg::STAT_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic [dps_pkg::ADDR_W-1:0] program_memory_address_bus,
  output logic pm_fetch_rd,
  input wire logic [dps_pkg::INSTR_W-1:0] pm_rdata,
  input wire logic pm_data_access,
  output logic [dps_pkg::INSTR_W-1:0] exec_instr,
  output logic exec_valid,
  input wire logic branch_req,
  input wire logic [dps_pkg::ADDR_W-1:0] branch_target,
  input wire logic cond_code_true,
  input wire logic cond_instr,
  input wire logic loop_push,
  input wire logic [dps_pkg::ADDR_W-1:0] loop_last_addr,
  input wire logic [dps_pkg::LOOP_CNT_W-1:0] loop_count_in,
  output logic loop_stack_full,
  input wire logic [dps_pkg::N_EXT_IRQ-1:0] ext_irq,
  input wire logic [dps_pkg::N_INT_IRQ-1:0] int_irq,
  input wire logic [dps_pkg::N_SW_IRQ-1:0] sw_irq,
  input wire logic rti,
  input wire logic [dps_pkg::ASTAT_W-1:0] astat_in,
  output logic [dps_pkg::ASTAT_W-1:0] astat_restore,
  output logic astat_restore_valid,
  input wire logic mode_wr,
  input wire logic [dps_pkg::MODE_W-1:0] mode_wdata,
  output logic [dps_pkg::MODE_W-1:0] primary_mode_control_word,
  output dps_pkg::dps_bank_sel_t bank_sel,
  output logic status_stack_overflow,
  input wire logic timer_enable,
  input wire logic timer_period_wr,
  input wire logic [dps_pkg::TIMER_W-1:0] timer_period_in,
  output logic [dps_pkg::TIMER_W-1:0] timer_count,
  output logic timer_expired_out
);
  localparam int AW = dps_pkg::ADDR_W;
  localparam int LPW = $clog2(LOOP_DEPTH + 1);
  localparam int SPW = $clog2(STAT_DEPTH + 1);

  typedef enum logic [1:0] {DPS_RUN, DPS_FLUSH} dps_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // State registers
  dps_state_t state_q;
  logic [AW-1:0] fetch_pc_q;
  dps_pkg::dps_stage_t dec_q;
  dps_pkg::dps_stage_t exe_q;
  logic fetch_pend_q;
  logic [AW-1:0] fetch_addr_q;
  logic fetch_from_cache_q;
  logic [dps_pkg::INSTR_W-1:0] cache_word_q;
  logic fill_pend_q;
  dps_pkg::dps_loop_t loop_stk_q [LOOP_DEPTH];
  logic [LPW-1:0] loop_sp_q;
  dps_pkg::dps_status_t stat_stk_q [STAT_DEPTH];
  logic [SPW-1:0] stat_sp_q;
  logic [dps_pkg::MODE_W-1:0] mode_q;
  logic [dps_pkg::N_IRQ-1:0] irq_lat_q;
  logic [dps_pkg::N_IRQ-1:0] irq_busy_q;
  logic [dps_pkg::TIMER_W-1:0] tcount_q;
  logic [dps_pkg::TIMER_W-1:0] tperiod_q;
  logic texp_q;
  logic [dps_pkg::ASTAT_W-1:0] astat_rst_q;
  logic astat_rst_v_q;
  logic ovf_q;
  logic fetch_rd_q;
  logic loop_full_q;

  ////////////////////////////////////////////////////////////////////////////
  // Cache
  logic c_hit;
  logic [dps_pkg::INSTR_W-1:0] c_word;

  // Fill in the cycle after a fetch lost to a data access
  wire fill_en = fill_pend_q; // RULE_08

  dps_icache u_cache (
    .clk(clk),
    .rst_n(rst_n),
    .lookup_addr(fetch_pc_q),
    .hit(c_hit),
    .hit_word(c_word),
    .fill_en(fill_en),
    .fill_addr(fetch_pc_q),
    .fill_word(pm_rdata)
  ); // RULE_07

  ////////////////////////////////////////////////////////////////////////////
  // Fetch arbitration
  // Data access owns memory; fetch stalls unless cache supplies the instruction
  wire use_cache = pm_data_access && c_hit; // RULE_09
  wire fetch_stall = pm_data_access && !c_hit;
  wire fetch_go = !fetch_stall && !fill_pend_q;
  wire [dps_pkg::INSTR_W-1:0] fetched_word = fetch_from_cache_q ? cache_word_q : pm_rdata; // RULE_03

  ////////////////////////////////////////////////////////////////////////////
  // Loop top-of-stack decode
  wire loop_active = loop_sp_q != '0;
  wire [LPW-1:0] loop_top = loop_sp_q - LPW'(1);
  dps_pkg::dps_loop_t top_loop;
  assign top_loop = loop_stk_q[loop_top];
  wire at_loop_end = loop_active && fetch_go && fetch_pc_q == top_loop.last;
  wire loop_again = at_loop_end && top_loop.count > dps_pkg::LOOP_CNT_W'(1); // RULE_19
  wire loop_pop = at_loop_end && !loop_again; // RULE_19
  assign loop_stack_full = loop_full_q;

  ////////////////////////////////////////////////////////////////////////////
  // Condition evaluation and branch take in execute
  wire take_branch = exe_q.valid && branch_req && (!cond_instr || cond_code_true); // RULE_04

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt priority: lowest index wins
  wire timer_zero = timer_enable && tcount_q == '0;
  wire [dps_pkg::N_IRQ-1:0] irq_src = {sw_irq, int_irq, ext_irq}; // RULE_13
  wire [dps_pkg::N_IRQ-1:0] irq_pend = irq_lat_q & ~irq_busy_q;
  wire irq_en = mode_q[dps_pkg::MODE_IRPTEN];
  logic [dps_pkg::IRQ_IDX_W-1:0] irq_idx;
  always_comb begin
    irq_idx = '0;
    for (int i = dps_pkg::N_IRQ - 1; i >= 0; i--) begin
      if (irq_pend[i]) begin
        irq_idx = dps_pkg::IRQ_IDX_W'(i);
      end
    end
  end
  // Accepted at any fetch point with no branch taken in execute, not just loop boundaries
  wire irq_take = irq_en && |irq_pend && !take_branch && fetch_go; // RULE_15
  wire stacks_status = irq_idx < dps_pkg::IRQ_IDX_W'(dps_pkg::N_EXT_IRQ + 1); // RULE_14
  wire stat_push = irq_take && stacks_status && stat_sp_q != SPW'(STAT_DEPTH);
  wire stat_pop = rti && stat_sp_q != '0;
  wire [SPW-1:0] stat_top = stat_sp_q - SPW'(1);
  wire [AW-1:0] irq_vector = dps_pkg::VECTOR_BASE + (AW'(irq_idx) << dps_pkg::VECTOR_SHIFT);
  wire [dps_pkg::N_IRQ-1:0] irq_onehot = dps_pkg::N_IRQ'(1) << irq_idx;

  ////////////////////////////////////////////////////////////////////////////
  // Next fetch address select
  logic [AW-1:0] pc_d;
  always_comb begin
    pc_d = fetch_pc_q;
    if (take_branch) begin
      pc_d = branch_target;
    end else if (irq_take) begin
      pc_d = irq_vector;
    end else if (loop_again) begin
      pc_d = top_loop.start; // RULE_05
    end else if (fetch_go) begin
      pc_d = fetch_pc_q + AW'(1); // RULE_01
    end
  end
  wire flush = take_branch || irq_take;

  ////////////////////////////////////////////////////////////////////////////
  // Fetch address and pipeline stages
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= DPS_RUN;
      fetch_pc_q <= dps_pkg::RESET_VECTOR;
      fetch_pend_q <= 1'b0;
      fetch_addr_q <= '0;
      fetch_from_cache_q <= 1'b0;
      cache_word_q <= '0;
      fill_pend_q <= 1'b0;
      fetch_rd_q <= 1'b0;
      dec_q <= '0;
      exe_q <= '0;
    end else begin
      state_q <= flush ? DPS_FLUSH : DPS_RUN;
      fetch_pc_q <= pc_d; // RULE_02
      fetch_pend_q <= fetch_go && !flush;
      fetch_addr_q <= fetch_pc_q;
      fetch_from_cache_q <= use_cache;
      cache_word_q <= c_word;
      fill_pend_q <= fetch_stall && !fill_pend_q && !flush; // RULE_08
      fetch_rd_q <= fetch_go && !flush && !use_cache; // RULE_09
      // Fetch -> decode -> execute overlap
      dec_q.valid <= fetch_pend_q && state_q == DPS_RUN && !flush; // RULE_06
      dec_q.addr <= fetch_addr_q;
      dec_q.word <= fetched_word;
      exe_q.valid <= dec_q.valid && !flush; // RULE_06
      exe_q.addr <= dec_q.addr;
      exe_q.word <= dec_q.word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Loop stack
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      loop_sp_q <= '0;
      loop_full_q <= 1'b0;
      for (int i = 0; i < LOOP_DEPTH; i++) begin
        loop_stk_q[i] <= '0;
      end
    end else if (loop_push && !loop_stack_full) begin
      loop_stk_q[loop_sp_q] <= '{start: exe_q.addr + AW'(1), last: loop_last_addr,
                                 count: loop_count_in}; // RULE_05
      loop_sp_q <= loop_sp_q + LPW'(1);
      loop_full_q <= loop_sp_q == LPW'(LOOP_DEPTH - 1);
    end else if (loop_again) begin
      loop_stk_q[loop_top].count <= top_loop.count - dps_pkg::LOOP_CNT_W'(1); // RULE_05
    end else if (loop_pop) begin
      loop_sp_q <= loop_top; // RULE_19
      loop_full_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt latch, status stack and mode word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_lat_q <= '0;
      irq_busy_q <= '0;
      stat_sp_q <= '0;
      mode_q <= dps_pkg::MODE_RESET; // RULE_10
      astat_rst_q <= '0;
      astat_rst_v_q <= 1'b0;
      ovf_q <= 1'b0;
      for (int i = 0; i < STAT_DEPTH; i++) begin
        stat_stk_q[i] <= '0;
      end
    end else begin
      // New requests win over the clear of the one taken
      irq_lat_q <= (irq_lat_q & ~(irq_take ? irq_onehot : '0)) | irq_src
                   | (timer_zero ? dps_pkg::N_IRQ'(1) << dps_pkg::TIMER_IRQ_BIT : '0); // RULE_15
      astat_rst_v_q <= stat_pop;
      if (irq_take && stacks_status && !stat_push) begin
        ovf_q <= 1'b1;
      end
      if (stat_push) begin
        stat_stk_q[stat_sp_q] <= '{astat: astat_in, mode: mode_q}; // RULE_14
        stat_sp_q <= stat_sp_q + SPW'(1);
      end else if (stat_pop) begin
        astat_rst_q <= stat_stk_q[stat_top].astat;
        mode_q <= stat_stk_q[stat_top].mode; // RULE_14
        stat_sp_q <= stat_top;
      end else if (mode_wr) begin
        mode_q <= mode_wdata; // RULE_20
      end
      if (irq_take) begin
        irq_busy_q <= irq_busy_q | irq_onehot;
      end else if (rti) begin
        irq_busy_q <= irq_busy_q & (irq_busy_q - dps_pkg::N_IRQ'(1));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interval timer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tcount_q <= '0;
      tperiod_q <= '0;
      texp_q <= 1'b0;
    end else begin
      if (timer_period_wr) begin
        tperiod_q <= timer_period_in;
      end
      texp_q <= timer_zero; // RULE_17
      if (timer_zero) begin
        tcount_q <= tperiod_q; // RULE_18
      end else if (timer_enable) begin
        tcount_q <= tcount_q - dps_pkg::TIMER_W'(1); // RULE_16
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each from a flip-flop
  // Bank selects only steer later accesses; banks are never copied
  assign bank_sel = '{data_lo: mode_q[dps_pkg::MODE_SRD_LO],
                      data_hi: mode_q[dps_pkg::MODE_SRD_HI], // RULE_11
                      agu1_lo: mode_q[dps_pkg::MODE_SAG1_LO],
                      agu1_hi: mode_q[dps_pkg::MODE_SAG1_HI], // RULE_12
                      agu2_lo: mode_q[dps_pkg::MODE_SAG2_LO],
                      agu2_hi: mode_q[dps_pkg::MODE_SAG2_HI],
                      mult_res: mode_q[dps_pkg::MODE_SMR]}; // RULE_10
  assign program_memory_address_bus = fetch_pc_q; // RULE_01
  assign pm_fetch_rd = fetch_rd_q;
  assign exec_instr = exe_q.word;
  assign exec_valid = exe_q.valid;
  assign primary_mode_control_word = mode_q;
  assign status_stack_overflow = ovf_q;
  assign astat_restore = astat_rst_q;
  assign astat_restore_valid = astat_rst_v_q;
  assign timer_count = tcount_q;
  assign timer_expired_out = texp_q;
endmodule

// ===== testbench/dps_sequencer_assertions.sv
// Concurrent checks on the program sequencer's ports.
// Assumes a bind onto dps_sequencer, one clock, async low reset.
`timescale 1ns/1ps
module dps_sequencer_assertions (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [dps_pkg::ADDR_W-1:0] program_memory_address_bus,
  input wire logic branch_req,
  input wire logic [dps_pkg::ADDR_W-1:0] branch_target,
  input wire logic cond_instr,
  input wire logic cond_code_true,
  input wire logic rti,
  input wire logic astat_restore_valid,
  input wire logic mode_wr,
  input wire logic [dps_pkg::MODE_W-1:0] mode_wdata,
  input wire logic [dps_pkg::MODE_W-1:0] primary_mode_control_word,
  input wire dps_pkg::dps_bank_sel_t bank_sel,
  input wire logic timer_enable,
  input wire logic timer_period_wr,
  input wire logic [dps_pkg::TIMER_W-1:0] timer_period_in,
  input wire logic [dps_pkg::TIMER_W-1:0] timer_count,
  input wire logic timer_expired_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [dps_pkg::ADDR_W-1:0] tgt_q;
  logic [dps_pkg::TIMER_W-1:0] period_q;
  logic [dps_pkg::ADDR_W-1:0] skip_q;
  // Last branch target and timer period seen
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tgt_q <= 24'h000000;
      period_q <= 32'h00000000;
      skip_q <= 24'h000000;
    end else begin
      tgt_q <= branch_req ? branch_target : tgt_q;
      skip_q <= (branch_req && cond_instr && !cond_code_true) ? branch_target : skip_q;
      period_q <= timer_period_wr ? timer_period_in : period_q;
    end
  end
  ////////////////////////////////////////
  // Steps of timer expiry and branching
  sequence tmr_zero;
    timer_enable && timer_count == 32'h0 && !timer_period_wr;
  endsequence
  sequence br_taken;
    branch_req && (!cond_instr || cond_code_true);
  endsequence
  sequence br_skip;
    branch_req && cond_instr && !cond_code_true;
  endsequence
  timer_step_a: assert property (
    timer_enable && timer_count != 32'h0 && !timer_period_wr
    |=> timer_count == $past(timer_count) - 32'h1)
    else $error("timer count did not step down");
  timer_fire_a: assert property (tmr_zero |=> timer_expired_out)
    else $error("timer expiry pulse missing");
  timer_reload_a: assert property (tmr_zero |=> timer_count == period_q)
    else $error("timer count not reloaded from period");
  expiry_cause_a: assert property (
    timer_expired_out |-> $past(timer_count) == 32'h0 && $past(timer_enable))
    else $error("timer expiry without zero count");
  mode_load_a: assert property (
    mode_wr |=> primary_mode_control_word == $past(mode_wdata))
    else $error("mode word not loaded");
  bank_map_a: assert property (
    bank_sel == {primary_mode_control_word[0], primary_mode_control_word[1],
                 primary_mode_control_word[2], primary_mode_control_word[3],
                 primary_mode_control_word[4], primary_mode_control_word[5],
                 primary_mode_control_word[6]})
    else $error("bank selects differ from mode word");
  branch_go_a: assert property (
    br_taken |-> ##[1:3] program_memory_address_bus == tgt_q)
    else $error("taken branch not fetched");
  branch_hold_a: assert property (
    br_skip |=> (program_memory_address_bus != skip_q) [*3])
    else $error("failed condition still branched");
  restore_cause_a: assert property (
    astat_restore_valid |-> $past(rti) || $past(rti, 2))
    else $error("status restore without return");
endmodule

bind dps_sequencer dps_sequencer_assertions u_chk (
  .clk, .rst_n, .program_memory_address_bus, .branch_req, .branch_target,
  .cond_instr, .cond_code_true, .rti, .astat_restore_valid, .mode_wr,
  .mode_wdata, .primary_mode_control_word, .bank_sel, .timer_enable,
  .timer_period_wr, .timer_period_in, .timer_count, .timer_expired_out
);

// ===== testbench/dps_pm_model.sv
// Program memory model answering instruction fetches.
// Assumes read data is sampled one cycle after the address.
`timescale 1ns/1ps
module dps_pm_model (
  input wire logic clk,
  input wire logic [dps_pkg::ADDR_W-1:0] addr,
  output logic [dps_pkg::INSTR_W-1:0] rdata
);
  // Each word is its address inverted, then the address
  initial rdata = 48'h000000000000;
  always @(posedge clk) begin
    rdata <= {~addr, addr};
  end
endmodule

// ===== testbench/dps_sequencer_tb.sv
// Self-checking bench for the program sequencer.
// Assumes dps_pkg, the memory model and the checker are compiled first.
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin miscompares++; \
  $display("Error at %0t: got %h expected %h", $time, a, e); end end
module dps_sequencer_tb;
  logic clk, rst_n, pm_fetch_rd, pm_data_access, exec_valid, branch_req;
  logic cond_code_true, cond_instr, loop_push, loop_stack_full, rti;
  logic astat_restore_valid, mode_wr, status_stack_overflow;
  logic timer_enable, timer_period_wr, timer_expired_out;
  logic [23:0] program_memory_address_bus, branch_target, loop_last_addr;
  logic [47:0] pm_rdata, exec_instr;
  logic [31:0] loop_count_in, astat_in, astat_restore, mode_wdata;
  logic [31:0] primary_mode_control_word, timer_period_in, timer_count;
  logic [3:0] ext_irq;
  logic [8:0] int_irq;
  logic [7:0] sw_irq;
  dps_pkg::dps_bank_sel_t bank_sel;
  int miscompares, checks, n;
  logic [23:0] lp_seq [7] = '{24'h101, 24'h102, 24'h103, 24'h101, 24'h102, 24'h103, 24'h104};
  logic [23:0] vec [3] = '{24'h000010, 24'h000028, 24'h000080};

  dps_sequencer DUT (
    .clk, .rst_n, .program_memory_address_bus, .pm_fetch_rd, .pm_rdata,
    .pm_data_access, .exec_instr, .exec_valid, .branch_req, .branch_target,
    .cond_code_true, .cond_instr, .loop_push, .loop_last_addr, .loop_count_in,
    .loop_stack_full, .ext_irq, .int_irq, .sw_irq, .rti, .astat_in,
    .astat_restore, .astat_restore_valid, .mode_wr, .mode_wdata,
    .primary_mode_control_word, .bank_sel, .status_stack_overflow,
    .timer_enable, .timer_period_wr, .timer_period_in, .timer_count,
    .timer_expired_out
  );
  dps_pm_model u_pm (.clk(clk), .addr(program_memory_address_bus), .rdata(pm_rdata));

  ////////////////////////////////////////
  // Expected memory word at an address
  function automatic logic [47:0] word(input logic [23:0] a);
    return {~a, a};
  endfunction

  // One cycle; single-cycle requests drop again
  task automatic tick();
    @(negedge clk);
    branch_req = 1'b0;
    loop_push = 1'b0;
    rti = 1'b0;
    mode_wr = 1'b0;
    timer_period_wr = 1'b0;
    ext_irq = 4'h0;
    int_irq = 9'h000;
    sw_irq = 8'h00;
  endtask

  // Next executed instruction must be the word at a
  task automatic nxt(input logic [23:0] a);
    n = 0;
    do begin
      tick();
      n++;
    end while (exec_valid !== 1'b1 && n < 20);
    `CHK(exec_instr, word(a))
  endtask

  // Bounded wait for the word at a in execute
  task automatic find(input logic [23:0] a);
    n = 0;
    do begin
      tick();
      n++;
    end while (!(exec_valid === 1'b1 && exec_instr === word(a)) && n < 30);
    `CHK(exec_instr, word(a))
  endtask

  // Bounded wait for a fetch address
  task automatic wait_addr(input logic [23:0] a);
    n = 0;
    do begin
      tick();
      n++;
    end while (program_memory_address_bus !== a && n < 20);
    `CHK(program_memory_address_bus, a)
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Core clock, 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Hang guard
  initial begin
    repeat (4000) @(posedge clk);
    miscompares++;
    finish_test();
  end

  // Test sequence
  initial begin
    miscompares = 0;
    checks = 0;
    rst_n = 1'b0;
    {pm_data_access, cond_code_true, cond_instr, timer_enable} = 4'h0;
    {branch_target, loop_last_addr} = 48'h0;
    {loop_count_in, astat_in, mode_wdata, timer_period_in} = 128'h0;
    tick();
    repeat (4) @(negedge clk);
    `CHK(program_memory_address_bus, 24'h000008)
    `CHK(exec_valid, 1'b0)
    `CHK(primary_mode_control_word, 32'h00000000)
    `CHK(bank_sel, 7'h00)
    `CHK(timer_count, 32'h00000000)
    rst_n = 1'b1;
    nxt(24'h000008);
    nxt(24'h000009);
    `CHK(pm_fetch_rd, 1'b1)
    nxt(24'h00000a);
    cond_instr = 1'b1;
    branch_target = 24'h000200;
    branch_req = 1'b1;
    nxt(24'h00000b);
    nxt(24'h00000c);
    cond_code_true = 1'b1;
    branch_target = 24'h000100;
    branch_req = 1'b1;
    find(24'h000100);
    loop_last_addr = 24'h000103;
    loop_count_in = 32'h00000002;
    loop_push = 1'b1;
    pm_data_access = 1'b1;
    foreach (lp_seq[i]) nxt(lp_seq[i]);
    pm_data_access = 1'b0;
    `CHK(loop_stack_full, 1'b0)
    mode_wdata = 32'h00001000;
    mode_wr = 1'b1;
    astat_in = 32'h0000a5a5;
    tick();
    `CHK(primary_mode_control_word, 32'h00001000)
    for (int k = 0; k < 3; k++) begin
      ext_irq = (k == 0) ? 4'h4 : 4'h0;
      int_irq = (k == 1) ? 9'h002 : 9'h000;
      sw_irq = (k == 2) ? 8'h08 : 8'h00;
      wait_addr(vec[k]);
      astat_in = 32'h00000000;
      rti = 1'b1;
      if (k == 0) begin
        n = 0;
        do begin
          tick();
          n++;
        end while (astat_restore_valid !== 1'b1 && n < 6);
        `CHK(astat_restore, 32'h0000a5a5)
      end
      astat_in = 32'h0000a5a5;
      tick();
    end
    for (int i = 0; i < 7; i++) begin
      mode_wdata = 32'h00000001 << i;
      mode_wr = 1'b1;
      tick();
      tick();
      `CHK(bank_sel, 7'h40 >> i)
    end
    timer_period_in = 32'h00000004;
    timer_period_wr = 1'b1;
    tick();
    timer_enable = 1'b1;
    n = 0;
    do begin
      tick();
      n++;
    end while (timer_expired_out !== 1'b1 && n < 12);
    `CHK(timer_count, 32'h00000004)
    n = 0;
    do begin
      tick();
      n++;
    end while (timer_expired_out !== 1'b1 && n < 12);
    `CHK(n, 5)
    timer_enable = 1'b0;
    tick();
    `CHK(status_stack_overflow, 1'b0)
    finish_test();
  end
endmodule
